// File: hw/rfs_pkg.sv
// Shared constants for the regulator fault supervisor.
// Assumes a single 100 MHz clock and comparator levels arriving as digital pins.
package rfs_pkg;

  localparam int CLK_MHZ = 100;

  // Register map, byte addresses on the plain register port.
  localparam int            ADDR_W      = 4;
  localparam logic [3:0]    ADDR_CTRL   = 4'h0;
  localparam logic [3:0]    ADDR_STATUS = 4'h4;
  localparam logic [3:0]    ADDR_OCPCNT = 4'h8;
  localparam int            CTRL_MODE_BIT = 0;
  localparam logic          CTRL_MODE_RST = 1'b0;

  // Status field positions.
  localparam int ST_STATE_LSB = 0;
  localparam int ST_PGOOD_BIT = 3;
  localparam int ST_OV1_BIT   = 4;
  localparam int ST_OV2_BIT   = 5;
  localparam int ST_UV_BIT    = 6;
  localparam int ST_TSD_BIT   = 7;
  localparam int ST_INPUT_UNDERVOLTAGE_LOCKOUT_BIT  = 8;
  localparam int ST_HALF_BIT  = 9;

  // Overcurrent pulse terminal counts.
  localparam int            OCP_CNT_W    = 7;
  localparam logic [6:0]    OCP_TERM_LOW = 7'h1E;
  localparam logic [6:0]    OCP_TERM_HI  = 7'h78;

  // Boot fault switching-cycle counts.
  localparam int            BOOT_CNT_W   = 6;
  localparam logic [5:0]    BOOT_MISS_CYC = 6'h0E;
  localparam logic [5:0]    BOOT_UV_CYC   = 6'h20;

  // Timing: time in its own unit, then cycles derived from the clock rate.
  localparam int OV_DEGLITCH_US = 30;
  localparam int OV_DEGLITCH_CYC = OV_DEGLITCH_US * CLK_MHZ;
  localparam int LEB_NS = 100;
  localparam int LEB_CYC = (LEB_NS * CLK_MHZ + 999) / 1000;
  localparam int PG_DELAY_US = 1000;
  localparam int PG_DELAY_CYC_DEF = PG_DELAY_US * CLK_MHZ;
  localparam int DG_W = 12;
  localparam int LEB_W = 4;
  localparam int PG_W = 20;

  typedef enum logic [2:0] {
    RFS_DISCH  = 3'b000,
    RFS_SOFT   = 3'b001,
    RFS_RUN    = 3'b010,
    RFS_HICCUP = 3'b011,
    RFS_LATCH  = 3'b100
  } rfs_state_e;

endpackage : rfs_pkg

// File: hw/rfs_supervisor.sv
// Fault supervisor: startup gating, power-good, lockout, overcurrent, boot, overvoltage.
// Assumes every comparator level arrives from the analog side asynchronously and
// that sw_cycle pulses once per switching cycle at high-side turn-on.
// Behaviour
// - With pre-bias, switching waits until soft-start minus offset reaches feedback.
// - Power-good rises only when feedback is in regulation, after a fixed delay.
// - Power-good drops at once on feedback overvoltage, undervoltage or overtemperature.
// - Other faults do not force power-good; it follows the sensed output.
// - Power-good is held low from power-up and through power-down.
// - Lockout keeps regulator off below start when rising, below stop when falling.
// - High-side current above short limit turns switch off and latches off.
// - Current above pulse limit of active mode leads to hiccup.
// - Overcurrent detection is blanked briefly after each high-side turn-on.
// - Pulse terminal count is 30 below 400 mV feedback, else 120.
// - At terminal count set hiccup latch and pull error amplifier output low.
// - Hiccup sinks soft-start; at low level clear latch, source, start soft-start.
// - Soft-start ramp after hiccup runs at half foldback frequency.
// - Hiccups repeat while short persists; recovery is automatic after removal.
// - Missing boot capacitor enters hiccup after 14 switching cycles.
// - Boot undervoltage enters hiccup after 32 switching cycles.
// - Boot faults use the hiccup retry and never latch.
// - First overvoltage level turns buck off, drives boost gate high, keeps power-good.
// - Second overvoltage level also pulls power-good low.
// - Overvoltage shorter than 30 us deglitch triggers no action.
// - Feedback below undervoltage threshold pulls power-good low.
// - Open feedback reads as overvoltage, disabling; recovery is automatic.
// - Overtemperature stops switching, drops power-good, resumes about 20 degrees lower.
// - Disable or fault sets fault latch with fast discharge until about 200 mV.
//
// Our own choices: strobed register access and the placing of the registers.
module rfs_supervisor #(
  parameter int PG_DELAY_CYC = rfs_pkg::PG_DELAY_CYC_DEF
) (
  input  wire logic                       clock,
  input  wire logic                       srst,
  input  wire logic [rfs_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [31:0]                reg_rdata,
  input  wire logic                       enable_pin,
  input  wire logic                       vin_above_start,
  input  wire logic                       vin_above_stop,
  input  wire logic                       sw_cycle,
  input  wire logic                       ss_reached_fb,
  input  wire logic                       ss_below_200mv,
  input  wire logic                       ss_hiccup_low,
  input  wire logic                       fb_in_reg,
  input  wire logic                       fb_above_400mv,
  input  wire logic                       fb_ov1,
  input  wire logic                       fb_ov2,
  input  wire logic                       fb_uv,
  input  wire logic                       temp_hot,
  input  wire logic                       temp_recovered,
  input  wire logic                       hs_over_lx_limit,
  input  wire logic                       hs_over_buck_limit,
  input  wire logic                       hs_over_bb_limit,
  input  wire logic                       boot_missing,
  input  wire logic                       boot_uv,
  output logic                            hs_enable,
  output logic                            boost_gate_drive,
  output logic                            erramp_enable,
  output logic                            comp_pulldown,
  output logic                            ss_source_en,
  output logic                            ss_sink_small_en,
  output logic                            ss_fast_discharge_en,
  output logic                            freq_half,
  output logic                            power_good_n_o,
  output logic                            power_good_n_oe
);
  import rfs_pkg::*;

  localparam int NSYNC = 19;

  function automatic logic reached(input logic [6:0] cnt, input logic [6:0] term);
    reached = (cnt >= term);
  endfunction : reached

  logic [NSYNC-1:0] meta_q, sync_q;
  logic             en_s, start_s, stop_s, cyc_s, ssfb_s, ss200_s, sslow_s, inreg_s;
  logic             fb400_s, ov1_s, ov2_s, uv_s, hot_s, cool_s, lx_s, ocb_s, ocbb_s;
  logic             bmiss_s, buv_s, cyc_prev_q, cyc_edge;
  rfs_state_e       state_q;
  logic             mode_bb_q, input_undervoltage_lockout_q, tsd_q, ov1_dg_q, ov2_dg_q, pg_q, oc_prev_q;
  logic [DG_W-1:0]  ov1_cnt_q, ov2_cnt_q;
  logic [LEB_W-1:0] leb_cnt_q;
  logic [PG_W-1:0]  pg_cnt_q;
  logic [OCP_CNT_W-1:0]  ocp_cnt_q;
  logic [BOOT_CNT_W-1:0] bmiss_cnt_q, buv_cnt_q;
  logic             switching, blanked, oc_now, oc_evt, lx_evt, ocp_hit, boot_hit, hiccup_evt;
  logic             pg_ok;
  logic [6:0]       ocp_term;

  // Two-flop synchronisers for every analog-side level.
  // Only the second stage is read, so a metastable first stage never reaches the logic.
  always_ff @(posedge clock) begin
    if (srst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {enable_pin, vin_above_start, vin_above_stop, sw_cycle, ss_reached_fb, ss_below_200mv,
                 ss_hiccup_low, fb_in_reg, fb_above_400mv, fb_ov1, fb_ov2, fb_uv, temp_hot,
                 temp_recovered, hs_over_lx_limit, hs_over_buck_limit, hs_over_bb_limit,
                 boot_missing, boot_uv};
      sync_q <= meta_q;
    end
  end
  assign {en_s, start_s, stop_s, cyc_s, ssfb_s, ss200_s, sslow_s, inreg_s, fb400_s, ov1_s, ov2_s,
          uv_s, hot_s, cool_s, lx_s, ocb_s, ocbb_s, bmiss_s, buv_s} = sync_q;

  always_ff @(posedge clock) begin
    if (srst) cyc_prev_q <= 1'b0;
    else      cyc_prev_q <= cyc_s;
  end
  assign cyc_edge = cyc_s & ~cyc_prev_q;

  // Register port: one control word, two status words, zero elsewhere.
  always_ff @(posedge clock) begin
    if (srst) mode_bb_q <= CTRL_MODE_RST;
    else if (reg_wr && reg_addr == ADDR_CTRL) mode_bb_q <= reg_wdata[CTRL_MODE_BIT];
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd && reg_addr == ADDR_CTRL) begin
      reg_rdata <= {31'h0000_0000, mode_bb_q};
    end else if (reg_rd && reg_addr == ADDR_STATUS) begin
      reg_rdata <= {22'h00_0000, freq_half, input_undervoltage_lockout_q, tsd_q, uv_s, ov2_dg_q, ov1_dg_q, pg_q, state_q};
    end else if (reg_rd && reg_addr == ADDR_OCPCNT) begin
      reg_rdata <= {25'h000_0000, ocp_cnt_q};
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // Lockout with hysteresis: off below stop, back on only above start.
  always_ff @(posedge clock) begin
    if (srst)         input_undervoltage_lockout_q <= 1'b1;
    else if (!stop_s) input_undervoltage_lockout_q <= 1'b1;
    else if (start_s) input_undervoltage_lockout_q <= 1'b0;
  end

  // Thermal shutdown clears only once the lower recovery comparator agrees.
  always_ff @(posedge clock) begin
    if (srst)                  tsd_q <= 1'b0;
    else if (hot_s)            tsd_q <= 1'b1;
    else if (cool_s)           tsd_q <= 1'b0;
  end

  // Overvoltage deglitch: a level must hold for the whole window before it acts.
  always_ff @(posedge clock) begin
    if (srst || !ov1_s) begin
      ov1_cnt_q <= '0;
      ov1_dg_q  <= 1'b0;
    end else if (ov1_cnt_q == DG_W'(OV_DEGLITCH_CYC - 1)) begin
      ov1_dg_q  <= 1'b1;
    end else begin
      ov1_cnt_q <= ov1_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst || !ov2_s) begin
      ov2_cnt_q <= '0;
      ov2_dg_q  <= 1'b0;
    end else if (ov2_cnt_q == DG_W'(OV_DEGLITCH_CYC - 1)) begin
      ov2_dg_q  <= 1'b1;
    end else begin
      ov2_cnt_q <= ov2_cnt_q + 1'b1;
    end
  end

  // Leading-edge blanking restarts at each high-side turn-on.
  always_ff @(posedge clock) begin
    if (srst)                       leb_cnt_q <= '0;
    else if (cyc_edge && switching) leb_cnt_q <= LEB_W'(LEB_CYC);
    else if (leb_cnt_q != '0)       leb_cnt_q <= leb_cnt_q - 1'b1;
  end

  assign switching = hs_enable;
  assign blanked   = (leb_cnt_q != '0) || (cyc_edge && switching);
  assign oc_now    = mode_bb_q ? ocbb_s : ocb_s;
  assign lx_evt    = lx_s && switching && !blanked;
  assign oc_evt    = oc_now && !oc_prev_q && switching && !blanked;
  assign ocp_term  = fb400_s ? OCP_TERM_HI : OCP_TERM_LOW;
  assign ocp_hit   = reached(ocp_cnt_q, ocp_term);
  assign boot_hit  = (bmiss_cnt_q >= BOOT_MISS_CYC) || (buv_cnt_q >= BOOT_UV_CYC);
  assign hiccup_evt = ocp_hit || boot_hit;

  always_ff @(posedge clock) begin
    if (srst) oc_prev_q <= 1'b0;
    else      oc_prev_q <= oc_now && !blanked;
  end

  // Pulse counter lives only while the supply is trying to deliver power.
  // Edges are counted, not cycles, so one long overcurrent pulse counts only once.
  always_ff @(posedge clock) begin
    if (srst || !(state_q == RFS_SOFT || state_q == RFS_RUN)) ocp_cnt_q <= '0;
    else if (oc_evt && !ocp_hit)                              ocp_cnt_q <= ocp_cnt_q + 1'b1;
  end

  // Boot faults count switching cycles while present; they never reach the latch.
  always_ff @(posedge clock) begin
    if (srst || !bmiss_s || state_q == RFS_HICCUP) bmiss_cnt_q <= '0;
    else if (cyc_edge && bmiss_cnt_q < BOOT_MISS_CYC) bmiss_cnt_q <= bmiss_cnt_q + 1'b1;
  end

  always_ff @(posedge clock) begin
    if (srst || !buv_s || state_q == RFS_HICCUP) buv_cnt_q <= '0;
    else if (cyc_edge && buv_cnt_q < BOOT_UV_CYC) buv_cnt_q <= buv_cnt_q + 1'b1;
  end

  // Sequencer. Disable and lockout outrank everything, including the short latch.
  always_ff @(posedge clock) begin
    if (srst || !en_s || input_undervoltage_lockout_q) begin
      state_q <= RFS_DISCH;
    end else begin
      case (state_q)
        RFS_LATCH:  state_q <= RFS_LATCH;
        RFS_DISCH:  if (ss200_s && !tsd_q) state_q <= RFS_SOFT;
        RFS_SOFT: begin
          if (lx_evt)          state_q <= RFS_LATCH;
          else if (tsd_q)      state_q <= RFS_DISCH;
          else if (hiccup_evt) state_q <= RFS_HICCUP;
          else if (ssfb_s)     state_q <= RFS_RUN;
        end
        RFS_RUN: begin
          if (lx_evt)          state_q <= RFS_LATCH;
          else if (tsd_q)      state_q <= RFS_DISCH;
          else if (hiccup_evt) state_q <= RFS_HICCUP;
        end
        RFS_HICCUP: begin
          // The switch can still be on in the first hiccup cycle, so a hard short is caught here too.
          if (lx_evt)          state_q <= RFS_LATCH;
          else if (tsd_q)      state_q <= RFS_DISCH;
          else if (sslow_s)    state_q <= RFS_SOFT;
        end
        default:               state_q <= RFS_DISCH;
      endcase
    end
  end

  // Half-rate foldback from the hiccup restart until the output is back in regulation.
  always_ff @(posedge clock) begin
    if (srst) freq_half <= 1'b0;
    else if (state_q == RFS_HICCUP && sslow_s) freq_half <= 1'b1;
    else if (inreg_s || state_q == RFS_DISCH || state_q == RFS_LATCH) freq_half <= 1'b0;
  end

  // Drive outputs, all registered.
  always_ff @(posedge clock) begin
    if (srst) begin
      hs_enable            <= 1'b0;
      boost_gate_drive     <= 1'b0;
      erramp_enable        <= 1'b0;
      comp_pulldown        <= 1'b0;
      ss_source_en         <= 1'b0;
      ss_sink_small_en     <= 1'b0;
      ss_fast_discharge_en <= 1'b1;
    end else begin
      hs_enable            <= state_q == RFS_RUN && !ov1_dg_q && !tsd_q && !lx_evt;
      boost_gate_drive     <= ov1_dg_q;
      erramp_enable        <= state_q == RFS_RUN;
      comp_pulldown        <= state_q == RFS_HICCUP;
      ss_source_en         <= state_q == RFS_SOFT || state_q == RFS_RUN;
      ss_sink_small_en     <= state_q == RFS_HICCUP;
      ss_fast_discharge_en <= state_q == RFS_DISCH || state_q == RFS_LATCH;
    end
  end

  // Power-good: slow to rise, immediate to fall. Other faults act only via the output.
  assign pg_ok = inreg_s && !ov2_dg_q && !uv_s && !tsd_q && en_s && !input_undervoltage_lockout_q;

  always_ff @(posedge clock) begin
    if (srst || !pg_ok) begin
      pg_cnt_q <= '0;
      pg_q     <= 1'b0;
    end else if (pg_cnt_q == PG_W'(PG_DELAY_CYC - 1)) begin
      pg_q     <= 1'b1;
    end else begin
      pg_cnt_q <= pg_cnt_q + 1'b1;
    end
  end

  // Open drain: the pin is pulled low whenever power is not good, including reset.
  assign power_good_n_o  = 1'b0;
  assign power_good_n_oe = !pg_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // Checks watch the synchronised view of the pins, so they trail a pin change by two cycles.
  // A check that looked at the raw pins would fire on a legal, still unsynchronised level.
  sequence s_hiccup_exit;
    state_q == RFS_HICCUP && sslow_s && en_s && !input_undervoltage_lockout_q && !tsd_q;
  endsequence

  sequence s_boot_trip;
    state_q == RFS_RUN && boot_hit && !lx_evt && !tsd_q && en_s && !input_undervoltage_lockout_q;
  endsequence

  chk_lx_latch_off: assert property (lx_evt && en_s && !input_undervoltage_lockout_q |=> state_q == RFS_LATCH ##1 !hs_enable)
    else $error("hard short did not latch off");
  chk_latch_holds: assert property (state_q == RFS_LATCH && en_s && !input_undervoltage_lockout_q |=> state_q == RFS_LATCH)
    else $error("short latch left without disable or lockout");
  chk_hiccup_entry: assert property (state_q == RFS_RUN && ocp_hit && !lx_evt && !tsd_q && en_s && !input_undervoltage_lockout_q
                                     |=> state_q == RFS_HICCUP ##1 comp_pulldown && ss_sink_small_en)
    else $error("terminal count did not start hiccup");
  chk_hiccup_exit: assert property (s_hiccup_exit |=> state_q == RFS_SOFT ##1
                                    ss_source_en && !ss_sink_small_en)
    else $error("hiccup did not restart soft-start");
  chk_half_freq: assert property (s_hiccup_exit |=> freq_half)
    else $error("restart after hiccup not at half frequency");
  chk_ocp_term: assert property (ocp_cnt_q <= OCP_TERM_HI and
                                 (!fb400_s && $past(!fb400_s) && $past(ocp_cnt_q) <= OCP_TERM_LOW
                                  |-> ocp_cnt_q <= OCP_TERM_LOW))
    else $error("pulse counter passed its terminal count");
  chk_ov_deglitch: assert property (!ov1_s |=> !ov1_dg_q ##1 !boost_gate_drive || ov1_dg_q)
    else $error("overvoltage acted before deglitch");
  chk_ov1_gate: assert property (ov1_dg_q |=> !hs_enable && boost_gate_drive)
    else $error("first overvoltage level did not stop buck");
  chk_pg_drop: assert property (uv_s || tsd_q || ov2_dg_q |=> power_good_n_oe)
    else $error("power-good not pulled low on fault");
  chk_pg_rise: assert property ($fell(power_good_n_oe) |-> $past(pg_ok) && pg_cnt_q == PG_W'(PG_DELAY_CYC - 1))
    else $error("power-good rose without full delay");
  chk_prebias_gate: assert property (hs_enable |-> $past(state_q) == RFS_RUN)
    else $error("switching before soft-start met feedback");
  chk_lockout: assert property (input_undervoltage_lockout_q |=> state_q == RFS_DISCH ##1 !hs_enable)
    else $error("regulator active under lockout");
  chk_boot_hiccup: assert property (s_boot_trip |=> state_q == RFS_HICCUP)
    else $error("boot fault did not start hiccup");
  chk_input_undervoltage_lockout_hyst: assert property (input_undervoltage_lockout_q && !start_s |=> input_undervoltage_lockout_q)
    else $error("lockout released below start threshold");
  chk_tsd_stop: assert property (tsd_q |=> !hs_enable && power_good_n_oe)
    else $error("overtemperature did not stop switching");
  chk_latch_release: assert property (state_q == RFS_LATCH && !en_s |=> state_q == RFS_DISCH)
    else $error("disable did not clear short latch");
  chk_pg_inreg: assert property (!power_good_n_oe |-> $past(inreg_s))
    else $error("power-good released with output out of regulation");
  chk_ov1_keeps_pg: assert property (ov1_dg_q && pg_ok && !power_good_n_oe |=> !power_good_n_oe)
    else $error("first overvoltage level dropped power-good");

endmodule : rfs_supervisor

// File: tb/rfs_power_stage.sv
// Behavioural model of the soft-start capacitor and its comparators on the analog side.
// Assumes the supervisor's soft-start current controls are levels sampled on the rising clock.
module rfs_power_stage (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       ss_source_en,
  input  wire logic       ss_sink_small_en,
  input  wire logic       ss_fast_discharge_en,
  input  wire logic [7:0] prebias,
  output logic            ss_reached_fb,
  output logic            ss_below_200mv,
  output logic            ss_hiccup_low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lvl_q;
  logic       half_q;

  // The small sink is slow on purpose, so the hiccup wait is far longer than a fast discharge.
  always_ff @(posedge clock) begin
    half_q <= srst ? 1'b0 : ~half_q;
    if (srst) begin
      lvl_q <= 8'h00;
    end else if (ss_fast_discharge_en) begin
      lvl_q <= (lvl_q > 8'h08) ? lvl_q - 8'h08 : 8'h00;
    end else if (ss_sink_small_en) begin
      if (half_q && lvl_q != 8'h00) lvl_q <= lvl_q - 8'h01;
    end else if (ss_source_en && lvl_q != 8'hFF) begin
      lvl_q <= lvl_q + 8'h01;
    end
  end

  // Soft-start minus its offset has to pass the pre-biased feedback level.
  assign ss_reached_fb  = {1'b0, lvl_q} > ({1'b0, prebias} + 9'h040);
  assign ss_below_200mv = lvl_q < 8'h20;
  assign ss_hiccup_low  = lvl_q < 8'h08;
endmodule : rfs_power_stage

// File: tb/rfs_supervisor_tb.sv
// Self-checking bench for the fault supervisor, driving comparator levels and the register port.
// Assumes the soft-start model in rfs_power_stage and a shortened power-good delay of 20 cycles.
`define CHK(nm, got, exp) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
  $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module rfs_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rfs_pkg::*;
  logic              clock, srst, reg_wr, reg_rd, enable_pin, vin_above_start, vin_above_stop, sw_cycle;
  logic              fb_in_reg, fb_above_400mv, fb_ov1, fb_ov2, fb_uv, temp_hot, temp_recovered;
  logic              hs_over_lx_limit, hs_over_buck_limit, hs_over_bb_limit, boot_missing, boot_uv;
  logic              ss_reached_fb, ss_below_200mv, ss_hiccup_low, hs_enable, boost_gate_drive;
  logic              erramp_enable, comp_pulldown, ss_source_en, ss_sink_small_en, ss_fast_discharge_en;
  logic              freq_half, power_good_n_o, power_good_n_oe, pg_pin;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0]       reg_wdata, reg_rdata, d;
  logic [7:0]        prebias;
  int                mismatches, comparisons;

  // Open-drain pin with an external pull-up.
  assign pg_pin = power_good_n_oe ? power_good_n_o : 1'b1;

  rfs_supervisor #(.PG_DELAY_CYC(20)) DUT (.clock(clock), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .enable_pin(enable_pin),
    .vin_above_start(vin_above_start), .vin_above_stop(vin_above_stop), .sw_cycle(sw_cycle),
    .ss_reached_fb(ss_reached_fb), .ss_below_200mv(ss_below_200mv), .ss_hiccup_low(ss_hiccup_low),
    .fb_in_reg(fb_in_reg), .fb_above_400mv(fb_above_400mv), .fb_ov1(fb_ov1), .fb_ov2(fb_ov2), .fb_uv(fb_uv),
    .temp_hot(temp_hot), .temp_recovered(temp_recovered), .hs_over_lx_limit(hs_over_lx_limit),
    .hs_over_buck_limit(hs_over_buck_limit), .hs_over_bb_limit(hs_over_bb_limit), .boot_missing(boot_missing),
    .boot_uv(boot_uv), .hs_enable(hs_enable), .boost_gate_drive(boost_gate_drive), .erramp_enable(erramp_enable),
    .comp_pulldown(comp_pulldown), .ss_source_en(ss_source_en), .ss_sink_small_en(ss_sink_small_en),
    .ss_fast_discharge_en(ss_fast_discharge_en), .freq_half(freq_half), .power_good_n_o(power_good_n_o),
    .power_good_n_oe(power_good_n_oe));

  rfs_power_stage ps (.clock(clock), .srst(srst), .ss_source_en(ss_source_en),
    .ss_sink_small_en(ss_sink_small_en), .ss_fast_discharge_en(ss_fast_discharge_en), .prebias(prebias),
    .ss_reached_fb(ss_reached_fb), .ss_below_200mv(ss_below_200mv), .ss_hiccup_low(ss_hiccup_low));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    @(posedge clock) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v; end
    @(posedge clock) reg_wr <= 1'b0;
  endtask : wr

  // Read data is only valid in the single cycle after the strobe.
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
    @(posedge clock) begin reg_rd <= 1'b1; reg_addr <= a; end
    @(posedge clock) reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic wait_state(input logic [2:0] s);
    int n;
    n = 0;
    d = '1;
    while (d[2:0] !== s && n < 3000) begin
      rd(ADDR_STATUS, d);
      n++;
    end
    if (d[2:0] !== s) begin
      mismatches++;
      $display("[ERR] state expected %0h seen %0h", s, d[2:0]);
      conclude();
    end
  endtask : wait_state

  task automatic set_lim(input int sel, input logic v);
    case (sel)
      0: hs_over_buck_limit <= v;
      1: hs_over_bb_limit <= v;
      2: hs_over_lx_limit <= v;
      default: ;
    endcase
  endtask : set_lim

  // One switching cycle; the chosen limit comparator fires gap cycles after the turn-on pulse ends.
  task automatic pulse(input int sel, input int gap);
    @(posedge clock) sw_cycle <= 1'b1;
    repeat (2) @(posedge clock);
    sw_cycle <= 1'b0;
    repeat (gap) @(posedge clock);
    set_lim(sel, 1'b1);
    repeat (2) @(posedge clock);
    set_lim(sel, 1'b0);
    repeat (3) @(posedge clock);
  endtask : pulse

  initial begin
    {reg_wr, reg_rd, sw_cycle, fb_in_reg, fb_above_400mv, fb_ov1, fb_ov2, fb_uv, temp_hot} = '0;
    {temp_recovered, hs_over_lx_limit, hs_over_buck_limit, hs_over_bb_limit, boot_missing, boot_uv} = '0;
    {vin_above_start, vin_above_stop, reg_addr, reg_wdata, mismatches, comparisons} = '0;
    srst = 1'b1;
    enable_pin = 1'b1;
    prebias = 8'h50;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock) #1;
    `CHK("pg_pin", pg_pin, 1'b0)
    `CHK("fast_dis", ss_fast_discharge_en, 1'b1)
    rd(ADDR_CTRL, d); `CHK("ctrl_rst", d, 32'h0000_0000)
    wr(ADDR_CTRL, 32'hFFFF_FFFF); rd(ADDR_CTRL, d); `CHK("ctrl_rw", d, 32'h0000_0001)
    rd(4'hC, d); `CHK("unmapped", d, 32'h0000_0000)
    wr(ADDR_CTRL, 32'h0000_0000);
    rd(ADDR_STATUS, d); `CHK("input_undervoltage_lockout", d[ST_INPUT_UNDERVOLTAGE_LOCKOUT_BIT], 1'b1)
    vin_above_stop <= 1'b1; repeat (10) @(posedge clock);
    rd(ADDR_STATUS, d); `CHK("input_undervoltage_lockout_hyst", d[ST_INPUT_UNDERVOLTAGE_LOCKOUT_BIT], 1'b1)
    vin_above_start <= 1'b1; wait_state(RFS_SOFT);
    `CHK("erramp_prebias", erramp_enable, 1'b0)
    wait_state(RFS_RUN); #1 `CHK("hs_run", {hs_enable, erramp_enable}, 2'b11)
    fb_in_reg <= 1'b1; repeat (14) @(posedge clock); #1 `CHK("pg_delay", pg_pin, 1'b0)
    repeat (20) @(posedge clock); #1 `CHK("pg_up", pg_pin, 1'b1)
    fb_uv <= 1'b1; repeat (5) @(posedge clock); #1 `CHK("pg_uv", pg_pin, 1'b0)
    fb_uv <= 1'b0; fb_ov1 <= 1'b1; repeat (2000) @(posedge clock); #1 `CHK("ov_glitch", boost_gate_drive, 1'b0)
    fb_ov1 <= 1'b0; repeat (10) @(posedge clock); fb_ov1 <= 1'b1; repeat (3100) @(posedge clock); #1
    `CHK("ov1_hs", {hs_enable, boost_gate_drive, pg_pin}, 3'b011)
    fb_ov2 <= 1'b1; repeat (3100) @(posedge clock); #1 `CHK("ov2_pg", pg_pin, 1'b0)
    {fb_ov1, fb_ov2} <= 2'b00; repeat (40) @(posedge clock); #1
    `CHK("ov_recover", {hs_enable, boost_gate_drive, pg_pin}, 3'b101)
    temp_hot <= 1'b1; repeat (5) @(posedge clock); #1 `CHK("tsd", {hs_enable, pg_pin}, 2'b00)
    repeat (20) @(posedge clock); temp_hot <= 1'b0; temp_recovered <= 1'b1;
    wait_state(RFS_RUN); temp_recovered <= 1'b0; prebias <= 8'h00; fb_in_reg <= 1'b0;
    wr(ADDR_CTRL, 32'h0000_0001); pulse(0, 14); rd(ADDR_OCPCNT, d); `CHK("bb_ign", d, 32'h0)
    pulse(1, 14); rd(ADDR_OCPCNT, d); `CHK("bb_cnt", d, 32'h1)
    wr(ADDR_CTRL, 32'h0000_0000); pulse(0, 1); rd(ADDR_OCPCNT, d); `CHK("blank", d, 32'h1)
    for (int i = 1; i < 29; i++) pulse(0, 14);
    rd(ADDR_OCPCNT, d); `CHK("ocp29", d[6:0], OCP_TERM_LOW - 7'h01)
    pulse(0, 14); wait_state(RFS_HICCUP); `CHK("comp_pd", comp_pulldown, 1'b1)
    `CHK("ss_sink", ss_sink_small_en, 1'b1)
    wait_state(RFS_SOFT); `CHK("half_freq", {freq_half, ss_source_en}, 2'b11)
    wait_state(RFS_RUN); fb_above_400mv <= 1'b1;
    for (int i = 0; i < 119; i++) pulse(0, 14);
    rd(ADDR_STATUS, d); `CHK("ocp_hi_run", d[2:0], RFS_RUN)
    pulse(0, 14); wait_state(RFS_HICCUP); wait_state(RFS_RUN); fb_above_400mv <= 1'b0;
    for (int s = 0; s < 2; s++) begin
      if (s == 0) boot_missing <= 1'b1;
      else boot_uv <= 1'b1;
      repeat ((s == 0) ? 13 : 31) pulse(3, 14);
      rd(ADDR_STATUS, d); `CHK("boot_early", d[2:0], RFS_RUN)
      pulse(3, 14); wait_state(RFS_HICCUP);
      {boot_missing, boot_uv} <= 2'b00; wait_state(RFS_RUN);
    end
    pulse(2, 1); rd(ADDR_STATUS, d); `CHK("lx_blank", d[2:0], RFS_RUN)
    pulse(2, 14); wait_state(RFS_LATCH); `CHK("lx_off", hs_enable, 1'b0)
    fb_in_reg <= 1'b1; repeat (300) @(posedge clock);
    rd(ADDR_STATUS, d); `CHK("lx_hold", d[2:0], RFS_LATCH)
    enable_pin <= 1'b0; repeat (10) @(posedge clock); enable_pin <= 1'b1;
    wait_state(RFS_RUN);
    conclude();
  end
endmodule : rfs_supervisor_tb
